// File: verilog/wdgo_pkg.sv
// constants, offsets and reset values for the watchdog, gate, pwm and vid option bank
package wdgo_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register indices; the byte address is four times the index
    localparam logic [7:0]  IDX_WDT_ACTION   = 8'h6b;
    localparam logic [7:0]  IDX_GATE_OPTION  = 8'h6c;
    localparam logic [7:0]  IDX_TEST         = 8'h6d;
    localparam logic [7:0]  IDX_VOLTAGE_ID_VALUE    = 8'h6e;
    localparam logic [7:0]  IDX_VID_CONTROL  = 8'h6f;
    localparam logic [7:0]  IDX_RECOVERY     = 8'h5f;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0]  RST_WDT_ACTION   = 8'h00;
    localparam logic [7:0]  RST_GATE_OPTION  = 8'h00;
    localparam logic [7:0]  RST_TEST         = 8'h00;
    localparam logic [7:0]  RST_VOLTAGE_ID_VALUE    = 8'h00;
    localparam logic        RST_VOLTAGE_ID_DIRECTION      = 1'b1;
    localparam logic        RST_FAN_START    = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int          WDT_PULSE_BIT    = 0;
    localparam int          WDT_GPIO_LSB     = 1;
    localparam logic [7:0]  WDT_USED_MASK    = 8'h1f;
    localparam int          GATE_MODE_BIT    = 7;
    localparam int          GATE_LOCK_BIT    = 6;
    localparam int          DUTY_FIRST_LSB   = 0;
    localparam int          DUTY_SECOND_LSB  = 2;
    localparam int          DUTY_THIRD_LSB   = 4;
    localparam int          VOLTAGE_ID_DIRECTION_BIT      = 1;
    localparam int          REC_START_BIT    = 0;
    localparam int          REC_RUN_BIT      = 1;

    ////////////////////////////////////////////////////////////////////////////
    // recovery duty cycles in percent
    localparam logic [6:0]  DUTY_PCT_00      = 7'h64;
    localparam logic [6:0]  DUTY_PCT_01      = 7'h46;
    localparam logic [6:0]  DUTY_PCT_10      = 7'h3c;
    localparam logic [6:0]  DUTY_PCT_11      = 7'h32;

    ////////////////////////////////////////////////////////////////////////////
    // timing: power-good pulse length
    localparam int          CLK_PERIOD_NS    = 10;
    localparam int          PG_PULSE_NS      = 1000;
    localparam int          PG_PULSE_CYC     = (PG_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////////
    // select code to percent
    function automatic logic [6:0] wdgo_duty_pct(input logic [1:0] code);
        logic [6:0] pct;
        pct = DUTY_PCT_00;
        unique case (code)
            2'b00: pct = DUTY_PCT_00;
            2'b01: pct = DUTY_PCT_01;
            2'b10: pct = DUTY_PCT_10;
            2'b11: pct = DUTY_PCT_11;
        endcase
        return pct;
    endfunction

endpackage : wdgo_pkg

// File: verilog/wdgo_pulse.sv
// fixed-length pulse generator for the power-good outputs
module wdgo_pulse
    import wdgo_pkg::*;
#(
    parameter int LEN = PG_PULSE_CYC
) (
    input  wire logic clk,
    input  wire logic srst,
    input  wire logic start,
    output logic      pulse,
    output logic      busy
);

    localparam int CW = $clog2(LEN + 1);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          pulse_q;
    logic          pulse_d;

    // next count: a start while idle loads the length minus one, otherwise count down to zero
    always_comb begin
        cnt_d   = cnt_q;
        pulse_d = pulse_q;
        if (start && !pulse_q) begin
            cnt_d   = CW'(LEN - 1);
            pulse_d = 1'b1;
        end else if (pulse_q) begin
            if (cnt_q == '0) begin
                pulse_d = 1'b0;
            end else begin
                cnt_d = cnt_q - CW'(1);
            end
        end
    end

    // register stage
    always_ff @(posedge clk) begin
        if (srst) begin
            cnt_q   <= '0;
            pulse_q <= 1'b0;
        end else begin
            cnt_q   <= cnt_d;
            pulse_q <= pulse_d;
        end
    end

    assign pulse = pulse_q;
    assign busy  = pulse_q;

endmodule // wdgo_pulse

// File: verilog/wdgo_top.sv
// option register bank: watchdog expiry actions, standby gate, fan recovery, vid pins
//
// Summary of operation
// - expiry pulses both power-good outputs when enabled
// - bits 1-3 toggle first three gpio polarities if output
// - fourth enable toggles fourth gpio polarity if output
// - gate bit 7 clear: second gate copies first, set: second gate takes the alternative input
// - lock bit 6 freezes bits 7:6 until reset
// - both resets clear the lock bit
// - battery reset clears gate register; standby keeps all but the lock bit
// - after ac failure start is 0, recovery duty
// - duty codes 100, 70, 60, 50 percent
// - duty fields at 5:4, 3:2, 1:0
// - voltage_id_value reads pin states as inputs
// - vid outputs driven from written value
// - direction bit: 0 output, 1 input
module wdgo_top
    import wdgo_pkg::*;
#(
    parameter int PULSE_LEN = PG_PULSE_CYC,
    parameter int VID_W     = 8
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             batt_por,
    // wishbone classic slave
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [9:0]       wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    // watchdog side
    input  wire logic             watchdog_timer_expired,
    input  wire logic [3:0]       general_output_config,
    output logic                  main_power_good_pulse,
    output logic                  cpu_power_good_pulse,
    output logic                  wd_gpio_first_toggle,
    output logic                  wd_gpio_second_toggle,
    output logic                  wd_gpio_third_toggle,
    output logic                  wd_gpio_fourth_toggle,
    // standby gates
    input  wire logic             standby_gate_first,
    input  wire logic             standby_gate_second_alt,
    output logic                  standby_gate_second,
    // fan recovery
    input  wire logic             ac_power_fail,
    input  wire logic             power_good_input,
    output logic                  fan_recovery_active,
    output logic      [6:0]       fan_pwm_first_duty,
    output logic      [6:0]       fan_pwm_second_duty,
    output logic      [6:0]       fan_pwm_third_duty,
    // voltage identification pins
    input  wire logic [VID_W-1:0] voltage_id_pins_in,
    output logic      [VID_W-1:0] voltage_id_pins_out,
    output logic      [VID_W-1:0] voltage_id_pins_oe
);

    ////////////////////////////////////////////////////////////////////////////
    // state
    logic [7:0]       wdt_act_q,  wdt_act_d;
    logic [7:0]       gate_q,     gate_d;
    logic [7:0]       test_q,     test_d;
    logic [VID_W-1:0] vid_val_q,  vid_val_d;
    logic             voltage_id_direction_q,  voltage_id_direction_d;
    logic             start_q,    start_d;
    logic             rec_wait_q, rec_wait_d;
    logic             rec_run_q,  rec_run_d;
    logic             exp_prev_q;
    logic             ack_q,      ack_d;
    logic [31:0]      dat_q,      dat_d;
    logic [3:0]       tog_q,      tog_d;
    logic             gate2_q,    gate2_d;
    logic [6:0]       duty1_q, duty2_q, duty3_q;
    logic [6:0]       duty1_d, duty2_d, duty3_d;
    logic [VID_W-1:0] vid_oe_q,   vid_oe_d;

    logic             req;
    logic             wr;
    logic [7:0]       idx;
    logic             exp_rise;
    logic             pg_start;
    logic             pg_busy;
    logic             pg_pulse;

    ////////////////////////////////////////////////////////////////////////////
    // bus decode: index is the word address
    assign idx      = wb_adr_i[9:2];
    assign req      = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr       = req && wb_we_i && wb_sel_i[0];
    assign exp_rise = watchdog_timer_expired && !exp_prev_q;
    assign pg_start = exp_rise && wdt_act_q[WDT_PULSE_BIT];

    // read mux
    function automatic logic [7:0] rd_byte(input logic [7:0] i);
        logic [7:0] v;
        v = 8'h00;
        unique case (i)
            IDX_WDT_ACTION:  v = wdt_act_q & WDT_USED_MASK;
            IDX_GATE_OPTION: v = gate_q;
            IDX_TEST:        v = test_q;
            IDX_VOLTAGE_ID_VALUE:   v = 8'(voltage_id_direction_q ? voltage_id_pins_in : vid_val_q);
            IDX_VID_CONTROL: v = {6'h00, voltage_id_direction_q, 1'b0};
            IDX_RECOVERY:    v = {6'h00, rec_run_q, start_q};
            default:         v = 8'h00;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // register file next values
    always_comb begin
        wdt_act_d = wdt_act_q;
        gate_d    = gate_q;
        test_d    = test_q;
        vid_val_d = vid_val_q;
        voltage_id_direction_d = voltage_id_direction_q;
        ack_d     = req;
        dat_d     = 32'h0000_0000;
        if (req && !wb_we_i) begin
            dat_d = {24'h00_0000, rd_byte(idx)};
        end
        if (wr) begin
            unique case (idx)
                IDX_WDT_ACTION: begin
                    wdt_act_d = wb_dat_i[7:0] & WDT_USED_MASK;
                end
                IDX_GATE_OPTION: begin
                    gate_d[5:0] = wb_dat_i[5:0];
                    if (!gate_q[GATE_LOCK_BIT]) begin
                        gate_d[7:6] = wb_dat_i[7:6];
                    end
                end
                IDX_TEST: begin
                    test_d = wb_dat_i[7:0];
                end
                IDX_VOLTAGE_ID_VALUE: begin
                    vid_val_d = wb_dat_i[VID_W-1:0];
                end
                IDX_VID_CONTROL: begin
                    voltage_id_direction_d = wb_dat_i[VOLTAGE_ID_DIRECTION_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // battery reset clears gate and test; standby reset only the lock bit
    always_ff @(posedge clk) begin
        if (batt_por) begin
            gate_q <= RST_GATE_OPTION;
            test_q <= RST_TEST;
        end else if (srst) begin
            gate_q[GATE_LOCK_BIT] <= 1'b0;
        end else begin
            gate_q <= gate_d;
            test_q <= test_d;
        end
    end

    // standby-rail registers and bus answer
    always_ff @(posedge clk) begin
        if (srst) begin
            wdt_act_q <= RST_WDT_ACTION;
            vid_val_q <= RST_VOLTAGE_ID_VALUE;
            voltage_id_direction_q <= RST_VOLTAGE_ID_DIRECTION;
            ack_q     <= 1'b0;
            dat_q     <= 32'h0000_0000;
        end else begin
            wdt_act_q <= wdt_act_d;
            vid_val_q <= vid_val_d;
            voltage_id_direction_q <= voltage_id_direction_d;
            ack_q     <= ack_d;
            dat_q     <= dat_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // watchdog expiry actions, fan recovery, gate and vid outputs
    always_comb begin
        tog_d      = 4'h0;
        start_d    = start_q;
        rec_wait_d = rec_wait_q;
        rec_run_d  = rec_run_q;
        duty1_d    = duty1_q;
        duty2_d    = duty2_q;
        duty3_d    = duty3_q;
        // one toggle pulse per expiry edge, gated by output config
        if (exp_rise) begin
            tog_d = wdt_act_q[WDT_GPIO_LSB +: 4] & general_output_config;
        end
        // software takes over the fans by writing start
        if (wr && idx == IDX_RECOVERY && wb_dat_i[REC_START_BIT]) begin
            start_d   = 1'b1;
            rec_run_d = 1'b0;
        end
        if (rec_wait_q && power_good_input) begin
            rec_wait_d = 1'b0;
            rec_run_d  = 1'b1;
        end
        // a power failure wins over a software start
        if (ac_power_fail) begin
            start_d    = 1'b0;
            rec_wait_d = 1'b1;
            rec_run_d  = 1'b0;
        end
        if (rec_run_d) begin
            duty1_d = wdgo_duty_pct(gate_q[DUTY_FIRST_LSB +: 2]);
            duty2_d = wdgo_duty_pct(gate_q[DUTY_SECOND_LSB +: 2]);
            duty3_d = wdgo_duty_pct(gate_q[DUTY_THIRD_LSB +: 2]);
        end
        // second gate copies the first in mode 0
        gate2_d  = gate_q[GATE_MODE_BIT] ? standby_gate_second_alt : standby_gate_first;
        vid_oe_d = voltage_id_direction_q ? {VID_W{1'b0}} : {VID_W{1'b1}};
    end

    // register stage
    always_ff @(posedge clk) begin
        if (srst) begin
            exp_prev_q <= 1'b0;
            tog_q      <= 4'h0;
            start_q    <= RST_FAN_START;
            rec_wait_q <= 1'b0;
            rec_run_q  <= 1'b0;
            duty1_q    <= DUTY_PCT_00;
            duty2_q    <= DUTY_PCT_00;
            duty3_q    <= DUTY_PCT_00;
            gate2_q    <= 1'b0;
            vid_oe_q   <= {VID_W{1'b0}};
        end else begin
            exp_prev_q <= watchdog_timer_expired;
            tog_q      <= tog_d;
            start_q    <= start_d;
            rec_wait_q <= rec_wait_d;
            rec_run_q  <= rec_run_d;
            duty1_q    <= duty1_d;
            duty2_q    <= duty2_d;
            duty3_q    <= duty3_d;
            gate2_q    <= gate2_d;
            vid_oe_q   <= vid_oe_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // shared power-good pulse for both outputs
    wdgo_pulse #(
        .LEN   (PULSE_LEN)
    ) u_pulse (
        .clk   (clk),
        .srst  (srst),
        .start (pg_start),
        .pulse (pg_pulse),
        .busy  (pg_busy)
    );

    // outputs
    assign wb_ack_o              = ack_q;
    assign wb_dat_o              = dat_q;
    assign main_power_good_pulse = pg_pulse;
    assign cpu_power_good_pulse  = pg_pulse;
    assign wd_gpio_first_toggle  = tog_q[0];
    assign wd_gpio_second_toggle = tog_q[1];
    assign wd_gpio_third_toggle  = tog_q[2];
    assign wd_gpio_fourth_toggle = tog_q[3];
    assign standby_gate_second   = gate2_q;
    assign fan_recovery_active   = rec_run_q;
    assign fan_pwm_first_duty    = duty1_q;
    assign fan_pwm_second_duty   = duty2_q;
    assign fan_pwm_third_duty    = duty3_q;
    assign voltage_id_pins_out   = vid_val_q;
    assign voltage_id_pins_oe    = vid_oe_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    pg_pulse_on_a: assert property (@(posedge clk) disable iff (srst)
        pg_start && !pg_busy |=> main_power_good_pulse && cpu_power_good_pulse)
        else $error("power-good pulse missing after expiry");

    pg_pulse_off_a: assert property (@(posedge clk) disable iff (srst)
        exp_rise && !wdt_act_q[WDT_PULSE_BIT] && !pg_busy |=> !main_power_good_pulse)
        else $error("power-good pulse while disabled");

    gpio_toggle_on_a: assert property (@(posedge clk) disable iff (srst)
        exp_rise && wdt_act_q[1] && general_output_config[0] |=> wd_gpio_first_toggle)
        else $error("first gpio toggle missing");

    fourth_gated_a: assert property (@(posedge clk) disable iff (srst)
        exp_rise && !(wdt_act_q[4] && general_output_config[3]) |=> !wd_gpio_fourth_toggle)
        else $error("fourth gpio toggled while not allowed");

    toggle_once_a: assert property (@(posedge clk) disable iff (srst)
        wd_gpio_fourth_toggle |=> !wd_gpio_fourth_toggle)
        else $error("gpio toggle longer than one cycle");

    gate_copy_a: assert property (@(posedge clk) disable iff (srst)
        !gate_q[GATE_MODE_BIT] && !batt_por |=> standby_gate_second == $past(standby_gate_first))
        else $error("second gate does not follow first");

    lock_hold_a: assert property (@(posedge clk) disable iff (srst)
        gate_q[GATE_LOCK_BIT] && !batt_por |=> $stable(gate_q[7:6]))
        else $error("locked gate bits changed");

    batt_clear_a: assert property (@(posedge clk) disable iff (srst)
        batt_por |=> gate_q == RST_GATE_OPTION)
        else $error("gate register not cleared by battery reset");

    fail_start_a: assert property (@(posedge clk) disable iff (srst)
        ac_power_fail |=> !start_q && !fan_recovery_active)
        else $error("start flag set after power failure");

    voltage_id_direction_a: assert property (@(posedge clk) disable iff (srst)
        !voltage_id_direction_q ##1 !voltage_id_direction_q |-> voltage_id_pins_oe == {VID_W{1'b1}})
        else $error("vid pins not driven in output mode");

    wdt_rsvd_a: assert property (@(posedge clk) disable iff (srst)
        req && !wb_we_i && idx == IDX_WDT_ACTION |=> wb_ack_o && wb_dat_o[7:5] == 3'h0)
        else $error("reserved watchdog bits read nonzero");

    ack_single_a: assert property (@(posedge clk) disable iff (srst)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

endmodule // wdgo_top

// File: tb/wdgo_top_tb_top.sv
// self-checking bench for the option register bank, with an integer reference model
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin errors++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module wdgo_top_tb_top
    import wdgo_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////
    // stimulus and observed signals
    localparam int PL = 3;
    logic        clk, srst, batt_por, cyc, stb, we, expired, g_first, g_alt, ac_fail, pg_in;
    logic [9:0]  adr;
    logic [3:0]  sel, gpo_cfg;
    logic [31:0] dat_i, dat_o;
    logic        ack, pg_main, pg_cpu, fan_act, g_second;
    logic [3:0]  tog;
    logic [6:0]  duty1, duty2, duty3;
    logic [7:0]  vid_in, vid_out, vid_oe, rd;
    int          errors, num_checks, m_wdt, m_gate, m_vid, m_en, m_cfg, c, i, k, r1, r2, n;

    ////////////////////////////////////////////////////////////////////////////
    // device under test, short power-good pulse
    wdgo_top #(.PULSE_LEN(PL), .VID_W(8)) dut_u (
        .clk(clk), .srst(srst), .batt_por(batt_por),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .watchdog_timer_expired(expired), .general_output_config(gpo_cfg),
        .main_power_good_pulse(pg_main), .cpu_power_good_pulse(pg_cpu),
        .wd_gpio_first_toggle(tog[0]), .wd_gpio_second_toggle(tog[1]),
        .wd_gpio_third_toggle(tog[2]), .wd_gpio_fourth_toggle(tog[3]),
        .standby_gate_first(g_first), .standby_gate_second_alt(g_alt),
        .standby_gate_second(g_second), .ac_power_fail(ac_fail),
        .power_good_input(pg_in), .fan_recovery_active(fan_act),
        .fan_pwm_first_duty(duty1), .fan_pwm_second_duty(duty2), .fan_pwm_third_duty(duty3),
        .voltage_id_pins_in(vid_in), .voltage_id_pins_out(vid_out), .voltage_id_pins_oe(vid_oe)
    );

    // free-running 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // model helpers and bus tasks
    function automatic logic [6:0] exp_pct(input int code);
        case (code & 3)
            0: return 7'h64;
            1: return 7'h46;
            2: return 7'h3c;
            default: return 7'h32;
        endcase
    endfunction

    task automatic stop_test();
        $display("checks=%0d errors=%0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // one classic cycle; waits for ack under a bound
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                      input logic [3:0] s);
        int t;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        sel <= s;
        dat_i <= {24'h00_0000, wd};
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (ack !== 1'b1 && t < 50);
        rd = dat_o[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (t >= 50) begin
            errors++;
            stop_test();
        end
    endtask

    task automatic wr(input logic [7:0] idx, input int d);
        wb(1'b1, idx, d[7:0], 4'h1);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input int e);
        wb(1'b0, idx, 8'h00, 4'h1);
        `CHK(rd, e[7:0])
    endtask

    // both power-on resets together, or one alone
    task automatic pulse_reset(input logic s, input logic b, input int cyc_n);
        @(posedge clk);
        srst <= s;
        batt_por <= b;
        repeat (cyc_n) @(posedge clk);
        srst <= 1'b0;
        batt_por <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // hang guard
    initial begin
        #1_000_000;
        errors++;
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        {cyc, stb, we, expired, g_first, g_alt, ac_fail, pg_in} = '0;
        srst = 1'b1;
        batt_por = 1'b1;
        adr = '0;
        sel = '0;
        dat_i = '0;
        gpo_cfg = '0;
        vid_in = '0;
        errors = 0;
        num_checks = 0;
        void'($urandom(91));
        pulse_reset(1'b1, 1'b1, 9);
        // reset values and an unmapped index
        rd_chk(IDX_WDT_ACTION, 0);
        rd_chk(IDX_GATE_OPTION, 0);
        rd_chk(IDX_TEST, 0);
        rd_chk(IDX_VID_CONTROL, 8'h02);
        wr(8'h10, 8'hff);
        rd_chk(8'h10, 0);
        wr(IDX_WDT_ACTION, 8'hff);
        rd_chk(IDX_WDT_ACTION, 8'h1f);
        wb(1'b1, IDX_WDT_ACTION, 8'h00, 4'he);
        rd_chk(IDX_WDT_ACTION, 8'h1f);
        // watchdog expiry actions with random enables and pin configuration
        for (i = 0; i < 6; i++) begin
            m_en = (i == 0) ? 0 : ((i == 1) ? 8'hff : $urandom);
            m_cfg = (i == 1) ? 4'hf : $urandom % 16;
            m_wdt = m_en & 8'h1f;
            wr(IDX_WDT_ACTION, m_en);
            rd_chk(IDX_WDT_ACTION, m_wdt);
            gpo_cfg <= m_cfg[3:0];
            expired <= 1'b1;
            @(posedge clk);
            @(negedge clk);
            `CHK(tog, 4'((m_wdt >> 1) & m_cfg))
            `CHK(pg_main, m_wdt[0])
            `CHK(pg_cpu, m_wdt[0])
            for (k = 1; k < PL; k++) begin
                @(negedge clk);
                `CHK({tog, pg_main, pg_cpu}, {4'h0, m_wdt[0], m_wdt[0]})
            end
            @(negedge clk);
            `CHK({pg_main, pg_cpu}, 2'b00)
            @(posedge clk);
            expired <= 1'b0;
            repeat (3) @(posedge clk);
        end
        // standby gate mode follows first gate or the alternative
        for (i = 0; i < 8; i++) begin
            m_gate = (i % 2) << 7;
            if (i % 4 == 0) wr(IDX_GATE_OPTION, m_gate);
            r1 = $urandom % 2;
            r2 = $urandom % 2;
            @(posedge clk);
            g_first <= r1[0];
            g_alt <= r2[0];
            wr(IDX_GATE_OPTION, m_gate);
            // gate output follows the mode one edge after the write lands
            @(negedge clk);
            `CHK(g_second, (i % 2) ? r2[0] : r1[0])
        end
        // recovery duty per select code after an ac failure
        for (c = 0; c < 4; c++) begin
            m_gate = (((c + 2) % 4) << 4) | (((c + 1) % 4) << 2) | c;
            wr(IDX_GATE_OPTION, m_gate);
            rd_chk(IDX_GATE_OPTION, m_gate);
            ac_fail <= 1'b1;
            @(posedge clk);
            ac_fail <= 1'b0;
            repeat (2) @(posedge clk);
            wb(1'b0, IDX_RECOVERY, 8'h00, 4'h1);
            `CHK(rd[0], 1'b0)
            `CHK(fan_act, 1'b0)
            pg_in <= 1'b1;
            n = 0;
            do begin
                @(negedge clk);
                n++;
            end while (fan_act !== 1'b1 && n < 20);
            `CHK(fan_act, 1'b1)
            if (fan_act !== 1'b1) begin
                stop_test();
            end
            `CHK(duty1, exp_pct(c))
            `CHK(duty2, exp_pct(c + 1))
            `CHK(duty3, exp_pct(c + 2))
            wr(IDX_RECOVERY, 8'h01);
            pg_in <= 1'b0;
        end
        // vid pins as inputs, then as outputs
        for (i = 0; i < 3; i++) begin
            r1 = $urandom % 256;
            vid_in <= r1[7:0];
            rd_chk(IDX_VOLTAGE_ID_VALUE, r1);
            `CHK(vid_oe, 8'h00)
        end
        m_vid = $urandom % 256;
        wr(IDX_VOLTAGE_ID_VALUE, m_vid);
        wr(IDX_VID_CONTROL, 8'h00);
        rd_chk(IDX_VOLTAGE_ID_VALUE, m_vid);
        `CHK(vid_out, m_vid[7:0])
        `CHK(vid_oe, 8'hff)
        // lock freezes mode and lock bits only
        wr(IDX_GATE_OPTION, 8'h40);
        wr(IDX_GATE_OPTION, 8'hc5);
        rd_chk(IDX_GATE_OPTION, 8'h45);
        wr(IDX_GATE_OPTION, 8'h0a);
        rd_chk(IDX_GATE_OPTION, 8'h4a);
        pulse_reset(1'b1, 1'b0, 2);
        rd_chk(IDX_GATE_OPTION, 8'h0a);
        rd_chk(IDX_WDT_ACTION, 0);
        `CHK(vid_oe, 8'h00)
        wr(IDX_GATE_OPTION, 8'h80);
        rd_chk(IDX_GATE_OPTION, 8'h80);
        wr(IDX_GATE_OPTION, 8'hc3);
        pulse_reset(1'b0, 1'b1, 2);
        rd_chk(IDX_GATE_OPTION, 8'h00);
        wr(IDX_GATE_OPTION, 8'h80);
        rd_chk(IDX_GATE_OPTION, 8'h80);
        stop_test();
    end

endmodule // wdgo_top_tb_top
